//--- core/mmd_pkg.sv
// Package for the dual-channel memory-to-memory copy engine
package mmd_pkg;
   localparam int          MMD_AW         = 20;
   localparam int          MMD_DW         = 8;
   localparam logic [19:0] MMD_STAGE_ADDR = 20'h00800;
   localparam logic [19:0] MMD_SRC_BASE   = 20'ha0000;
   localparam logic [19:0] MMD_DST_BASE   = 20'hc0000;
   localparam logic [8:0]  MMD_BLOCK_LEN  = 9'h080;
   localparam logic [19:0] MMD_PTR_STEP   = 20'h00001;

   typedef enum logic [2:0] {
      MMD_IDLE  = 3'b000,
      MMD_C0_RD = 3'b001,
      MMD_C0_WR = 3'b010,
      MMD_C1_RD = 3'b011,
      MMD_C1_WR = 3'b100
   } mmd_state_e;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } mmd_bus_req_s;
endpackage

//--- core/mmd_dma.sv
// Dual-channel DMA copying one staged byte per periodic timer request
//
// Contract
// R1: Simultaneous requests: channel zero granted first, channel one after it.
// R2: Each timer request raises requests on both channels together.
// R3: Channel zero reads source byte, writes staging RAM, increments source.
// R4: Channel one reads staging byte, writes destination, increments dest.
// R5: Copy covers 128 contiguous bytes from source base to dest base.
// R6: Per-channel byte count; exhausted channel ignores requests until reloaded.
`timescale 1ns/1ns
module mmd_dma
   import mmd_pkg::*;
#(
   parameter logic [19:0] SRC_BASE  = MMD_SRC_BASE,
   parameter logic [19:0] DST_BASE  = MMD_DST_BASE,
   parameter logic [8:0]  BLOCK_LEN = MMD_BLOCK_LEN
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic         timer_req,
   input  wire logic         reload,
   output mmd_bus_req_s      mem_req,
   input  wire logic         mem_ack,
   input  wire logic [7:0]   mem_rdata,
   output logic              busy,
   output logic              done,
   output logic [8:0]        count_zero,
   output logic [8:0]        count_one
);
   mmd_state_e  state;
   mmd_state_e  next_state;
   logic        pend_zero;
   logic        pend_one;
   logic [19:0] src_ptr;
   logic [19:0] dst_ptr;
   logic [7:0]  data_hold;
   logic        step;
   logic        take_zero;
   logic        take_one;
   logic        fin_zero;
   logic        fin_one;

   // Last access of a channel's byte, shared by pending clear and pointers
   function automatic logic last_access(input mmd_state_e cur,
                                        input mmd_state_e wr_state,
                                        input logic       fire);
      return (cur == wr_state) && fire;
   endfunction

   // A request counts only while the channel still has bytes left
   function automatic logic accept_req(input logic       req_in,
                                       input logic [8:0] left);
      return req_in && (left != 9'h000);
   endfunction

   assign step = mem_req.req && mem_ack;

   // R6 exhausted channel ignores request
   assign take_zero = accept_req(timer_req, count_zero);
   assign take_one  = accept_req(timer_req, count_one);

   assign fin_zero = last_access(state, MMD_C0_WR, step);
   assign fin_one  = last_access(state, MMD_C1_WR, step);

   // R2 both requests: set wins over service clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst || reload)
         pend_zero <= 1'b0;
      else if (take_zero)
         pend_zero <= 1'b1;
      else if (fin_zero)
         pend_zero <= 1'b0;
   end

   // R2 channel one pends on the same request
   always_ff @(posedge clk_sys) begin
      if (sys_rst || reload)
         pend_one <= 1'b0;
      else if (take_one)
         pend_one <= 1'b1;
      else if (fin_one)
         pend_one <= 1'b0;
   end

   // R1 fixed priority arbitration
   always_comb begin
      next_state = state;
      case (state)
         MMD_IDLE: begin
            // Fresh request starts at once, saving a cycle of latency
            if (pend_zero || take_zero)
               next_state = MMD_C0_RD;
            else if (pend_one || take_one)
               next_state = MMD_C1_RD;
         end
         MMD_C0_RD: begin
            if (step)
               next_state = MMD_C0_WR;
         end
         MMD_C0_WR: begin
            // Channel one waits for channel zero to finish its byte
            if (step)
               next_state = pend_one ? MMD_C1_RD : MMD_IDLE;
         end
         MMD_C1_RD: begin
            if (step)
               next_state = MMD_C1_WR;
         end
         MMD_C1_WR: begin
            if (step)
               next_state = MMD_IDLE;
         end
         default: next_state = MMD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         state <= MMD_IDLE;
      else if (reload)
         state <= MMD_IDLE;
      else
         state <= next_state;
   end

   // Bus request decode per state
   always_comb begin
      mem_req = '0;
      case (state)
         MMD_C0_RD: begin
            mem_req.req  = 1'b1;
            mem_req.addr = src_ptr;
         end
         MMD_C0_WR: begin
            mem_req.req   = 1'b1;
            mem_req.we    = 1'b1;
            mem_req.addr  = MMD_STAGE_ADDR;
            mem_req.wdata = data_hold;
         end
         MMD_C1_RD: begin
            mem_req.req  = 1'b1;
            mem_req.addr = MMD_STAGE_ADDR;
         end
         MMD_C1_WR: begin
            mem_req.req   = 1'b1;
            mem_req.we    = 1'b1;
            mem_req.addr  = dst_ptr;
            mem_req.wdata = data_hold;
         end
         default: mem_req = '0;
      endcase
   end

   // Read data latched for the following write
   always_ff @(posedge clk_sys) begin
      if (sys_rst)
         data_hold <= 8'h00;
      else if (step && !mem_req.we)
         data_hold <= mem_rdata;
   end

   // R3 source side and R5 base load
   always_ff @(posedge clk_sys) begin
      if (sys_rst || reload) begin
         src_ptr    <= SRC_BASE;
         count_zero <= BLOCK_LEN;
      end else if (fin_zero) begin
         src_ptr    <= src_ptr + MMD_PTR_STEP;
         count_zero <= count_zero - 9'h001;
      end
   end

   // R4 destination side, R6 count down
   always_ff @(posedge clk_sys) begin
      if (sys_rst || reload) begin
         dst_ptr   <= DST_BASE;
         count_one <= BLOCK_LEN;
      end else if (fin_one) begin
         dst_ptr   <= dst_ptr + MMD_PTR_STEP;
         count_one <= count_one - 9'h001;
      end
   end

   assign busy = (state != MMD_IDLE);
   // Done once both channels have moved the whole block
   assign done = (count_zero == 9'h000) && (count_one == 9'h000) && !busy;
endmodule

//--- dv/mmd_mem.sv
// Memory model answering the copy engine
`timescale 1ns/1ns
module mmd_mem
   import mmd_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    slow,
   input  mmd_bus_req_s mem_req,
   output logic         mem_ack,
   output logic [7:0]   mem_rdata,
   output logic [7:0]   dst [128]
);
   logic       tick = 1'b0;
   logic [7:0] stage = 8'h00;
   logic [7:0] v;
   assign mem_ack = mem_req.req && (!slow || tick);
   assign v = mem_req.addr == MMD_STAGE_ADDR ? stage : mem_req.addr[7:0];
   // Inverse data whenever no ack is given, idle or waiting, so a stale value never passes
   assign mem_rdata = mem_ack ? v : ~v;
   always_ff @(posedge clk_sys) begin
      tick <= !tick;
      if (mem_ack && mem_req.we)
         if (mem_req.addr == MMD_STAGE_ADDR) stage <= mem_req.wdata;
         else dst[mem_req.addr[6:0]] <= mem_req.wdata;
   end
endmodule

//--- dv/mmd_dma_props.sv
// Checker for the copy engine ports
`timescale 1ns/1ns
module mmd_dma_props
   import mmd_pkg::*;
#(
   parameter logic [19:0] SRC_BASE  = MMD_SRC_BASE,
   parameter logic [19:0] DST_BASE  = MMD_DST_BASE,
   parameter logic [8:0]  BLOCK_LEN = MMD_BLOCK_LEN
) (
   input wire logic         clk_sys,
   input wire logic         sys_rst,
   input wire logic         timer_req,
   input wire logic         reload,
   input mmd_bus_req_s      mem_req,
   input wire logic         mem_ack,
   input wire logic [7:0]   mem_rdata,
   input wire logic         busy,
   input wire logic         done,
   input wire logic [8:0]   count_zero,
   input wire logic [8:0]   count_one
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence rd_src; mem_req.req && !mem_req.we && mem_ack &&
      mem_req.addr != MMD_STAGE_ADDR; endsequence
   sequence rd_stg; mem_req.req && !mem_req.we && mem_ack &&
      mem_req.addr == MMD_STAGE_ADDR; endsequence
   zero_first_a: assert property (timer_req && !busy && !reload &&
      count_zero != 9'h000 |=> mem_req.req && !mem_req.we && mem_req.addr
      == SRC_BASE + 20'(BLOCK_LEN - $past(count_zero))) else $error("no c0");
   stage_write_a: assert property (rd_src |=> mem_req.we &&
      mem_req.addr == MMD_STAGE_ADDR && mem_req.wdata == $past(mem_rdata))
      else $error("bad stage write");
   dest_write_a: assert property (rd_stg |=> mem_req.we &&
      mem_req.addr == DST_BASE + 20'(BLOCK_LEN - count_one) &&
      mem_req.wdata == $past(mem_rdata)) else $error("bad dest write");
   count_step_a: assert property (count_zero != $past(count_zero) &&
      !$past(reload) |-> count_zero == $past(count_zero) - 9'h001)
      else $error("bad count step");
   both_served_a: assert property (rd_src |-> ##[1:20] rd_stg)
      else $error("c1 not served");
   exhausted_a: assert property (done && !reload |=> !mem_req.req)
      else $error("run past block");
endmodule
bind mmd_dma mmd_dma_props #(.SRC_BASE(SRC_BASE), .DST_BASE(DST_BASE),
   .BLOCK_LEN(BLOCK_LEN)) u_mmd_dma_props (.*);

//--- dv/mmd_dma_tb_top.sv
// Bench for the copy engine
`timescale 1ns/1ns
module mmd_dma_tb_top;
   import mmd_pkg::*;
   logic clk_sys = 0, sys_rst = 1, timer_req = 0, reload = 0, slow = 0;
   logic mem_ack, busy, done;
   logic [7:0] mem_rdata;
   logic [7:0] dst [128];
   logic [8:0] count_zero, count_one;
   mmd_bus_req_s mem_req;
   int n_errors = 0, num_checks = 0;
   mmd_dma u_mmd_dma (.clk_sys, .sys_rst, .timer_req, .reload, .mem_req,
      .mem_ack, .mem_rdata, .busy, .done, .count_zero, .count_one);
   mmd_mem u_mmd_mem (.clk_sys, .slow, .mem_req, .mem_ack, .mem_rdata, .dst);
   initial forever #5 clk_sys = !clk_sys;
   task automatic check(input logic [8:0] seen, exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic pulse();
      timer_req = 1;
      @(posedge clk_sys) #1 timer_req = 0;
      for (int w = 0; w < 20 && busy !== 1'b0; w++) @(posedge clk_sys) #1;
   endtask
   task automatic run_block(input logic s);
      slow = s;
      for (int i = 0; i < 128; i++) pulse();
      for (int i = 0; i < 128; i++) check(dst[i], 9'(i), "dst");
      check(count_one, 9'h000, "cnt1");
      check(done, 9'h001, "done");
   endtask
   task automatic refuse();
      pulse();
      check(mem_req.req, 9'h000, "req");
      check(busy, 9'h000, "busy");
      check(count_zero, 9'h000, "cnt0");
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 sys_rst = 0;
      check(count_zero, 9'h080, "cnt0");
      run_block(0);
      refuse();
      reload = 1;
      @(posedge clk_sys) #1 reload = 0;
      check(count_one, 9'h080, "cnt1");
      run_block(1);
      stop_test();
   end
   initial begin
      #100000 n_errors++;
      stop_test();
   end
endmodule
